/* File: design/pdseq_pkg.sv */
// How it works
// - Sink emits Hard Reset signaling, then tells the power path to prepare.
// - Sink finishes preparation within the prepare limit and raises a completion pulse.
// - Source raises a notify pulse when Hard Reset signaling arrives from the Sink while idle or in a no-change exchange.
// - Source waits the reset delay, orders supply reset; bus reaches zero within limit.
// - Source re-applies default power after recovery; bus reaches default within limit.
// - Source answers a same voltage and current request with Accept.
// - Sink starts the power transition timer when Accept arrives.
// - Receiver returns GoodCRC for Accept before evaluating it; Source waits for it.
// - Source waits the transition delay after acknowledged Accept, then sends PS_RDY.
// - Sink returns GoodCRC on PS_RDY, then evaluates it and completes the exchange.
// - No-change decision may come from the policy manager or the supply control.
`default_nettype none
package pdseq_pkg;
    // Clock rate and timer width
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned TMR_W   = 32;

    // Times in microseconds; plain defaults, a board sets the real figures
    localparam int unsigned SINK_RESET_PREPARE_LIMIT_US = 10000;
    localparam int unsigned SOURCE_RESET_WAIT_DELAY_US  = 20000;
    localparam int unsigned DISCHARGE_TIME_LIMIT_US     = 500000;
    localparam int unsigned SOURCE_RECOVERY_DELAY_US    = 500000;
    localparam int unsigned SOURCE_TURN_ON_LIMIT_US     = 200000;
    localparam int unsigned SOURCE_TRANSITION_DELAY_US  = 20000;
    localparam int unsigned POWER_TRANSITION_TIMER_US   = 500000;

    // Cycle counts derived from the times (whole microseconds give exact counts)
    localparam int unsigned SINK_PREP_CYC  = SINK_RESET_PREPARE_LIMIT_US * CLK_MHZ;
    localparam int unsigned SRC_WAIT_CYC   = SOURCE_RESET_WAIT_DELAY_US * CLK_MHZ;
    localparam int unsigned DISCHARGE_CYC  = DISCHARGE_TIME_LIMIT_US * CLK_MHZ;
    localparam int unsigned RECOVERY_CYC   = SOURCE_RECOVERY_DELAY_US * CLK_MHZ;
    localparam int unsigned TURN_ON_CYC    = SOURCE_TURN_ON_LIMIT_US * CLK_MHZ;
    localparam int unsigned TRANSITION_CYC = SOURCE_TRANSITION_DELAY_US * CLK_MHZ;
    localparam int unsigned PST_CYC        = POWER_TRANSITION_TIMER_US * CLK_MHZ;

    // Sequencer states
    typedef enum logic [10:0] {
        ST_IDLE        = 11'h001,
        ST_SNK_SIGNAL  = 11'h002,
        ST_SNK_PREP    = 11'h004,
        ST_SNK_WAIT    = 11'h008,
        ST_SRC_HR_WAIT = 11'h010,
        ST_SRC_DISCH   = 11'h020,
        ST_SRC_RECOVER = 11'h040,
        ST_SRC_TURN_ON = 11'h080,
        ST_SRC_ACC_ACK = 11'h100,
        ST_SRC_TRANS   = 11'h200,
        ST_SRC_RDY_ACK = 11'h400
    } pdseq_state_e;

    // Index of each bus level in the synchroniser vectors
    localparam int unsigned LVL_ZERO = 0;
    localparam int unsigned LVL_DEF  = 1;

    // Sequencer state
    typedef struct packed {
        pdseq_state_e state;
        logic [1:0]   sync0;
        logic [1:0]   sync1;
        logic [1:0]   sync2;
        logic [1:0]   lvl;
        logic         tx_hard_reset;
        logic         prepare_req;
        logic         prep_done_ind;
        logic         prep_late;
        logic         hr_notify;
        logic         reset_order;
        logic         vbus_enable;
        logic         discharge_fault;
        logic         turnon_fault;
        logic         hr_complete;
        logic         tx_accept;
        logic         goodcrc_tx;
        logic         tx_ps_rdy;
        logic         pst_running;
        logic         pst_fail;
        logic         exchange_done;
    } pdseq_top_s;

    localparam pdseq_top_s TOP_RST = '{state: ST_IDLE, vbus_enable: 1'h1, default: '0};

    // Timer state
    typedef struct packed {
        logic             run;
        logic [TMR_W-1:0] cnt;
        logic             done;
    } pdseq_tmr_s;

    localparam pdseq_tmr_s TMR_RST = '{default: '0};
endpackage
`default_nettype wire

/* File: design/pdseq_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Down counter; done pulses load_val cycles after the start cycle
module pdseq_timer
    import pdseq_pkg::*;
(
    // Clock and reset
    input  wire logic  ref_clk,
    input  wire logic  resetn,
    // Control
    pdseq_tmr_if.tmr   t
);
    pdseq_tmr_s r_reg;
    pdseq_tmr_s r_next;

    assign t.done = r_reg.done;

    // Start wins over stop so a phase can end and the next begin in one cycle
    always_comb begin
        r_next      = r_reg;
        r_next.done = 1'h0;
        if (t.start) begin
            // The start cycle counts as the first, so a load of one ends at once
            r_next.run  = (t.load_val > {{(TMR_W-1){1'b0}}, 1'b1});
            r_next.cnt  = t.load_val - {{(TMR_W-1){1'b0}}, 1'b1};
            r_next.done = (t.load_val == {{(TMR_W-1){1'b0}}, 1'b1});
        end else if (t.stop) begin
            r_next.run = 1'h0;
        end else if (r_reg.run) begin
            if (r_reg.cnt == {{(TMR_W-1){1'b0}}, 1'b1}) begin
                r_next.run  = 1'h0;
                r_next.done = 1'h1;
            end
            r_next.cnt = r_reg.cnt - {{(TMR_W-1){1'b0}}, 1'b1};
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            r_reg <= TMR_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // A two-cycle load ends with done exactly two cycles later
    a_timer_two_cycle:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        (t.start && t.load_val == 32'h2) ##1 (!t.start && !t.stop) |-> !t.done ##1 t.done)
        else $error("timer did not expire after two cycles");
endmodule
`default_nettype wire

/* File: design/pdseq_tmr_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Control link between the sequencer and its single shared timer
interface pdseq_tmr_if;
    import pdseq_pkg::*;
    logic             start;
    logic             stop;
    logic [TMR_W-1:0] load_val;
    logic             done;
    modport ctrl (output start, output stop, output load_val, input done);
    modport tmr  (input start, input stop, input load_val, output done);
endinterface
`default_nettype wire

/* File: design/pdseq_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Hard Reset and no-change contract sequencer for one port policy engine
module pdseq_top
    import pdseq_pkg::*;
#(
    parameter int unsigned SINK_PREP_CYCLES  = SINK_PREP_CYC,
    parameter int unsigned SRC_WAIT_CYCLES   = SRC_WAIT_CYC,
    parameter int unsigned DISCHARGE_CYCLES  = DISCHARGE_CYC,
    parameter int unsigned RECOVERY_CYCLES   = RECOVERY_CYC,
    parameter int unsigned TURN_ON_CYCLES    = TURN_ON_CYC,
    parameter int unsigned TRANSITION_CYCLES = TRANSITION_CYC,
    parameter int unsigned PST_CYCLES        = PST_CYC
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic resetn,
    // Role and policy manager requests
    input  wire logic role_source,
    input  wire logic sink_hr_req,
    input  wire logic no_change_dpm,
    input  wire logic no_change_supply,
    // Power path and bus comparators (comparators are asynchronous pins)
    input  wire logic prep_ready,
    input  wire logic vbus_at_zero_pin,
    input  wire logic vbus_at_default_pin,
    // Protocol layer events
    input  wire logic hard_reset_rx,
    input  wire logic same_req_rx,
    input  wire logic accept_rx,
    input  wire logic ps_rdy_rx,
    input  wire logic goodcrc_rx,
    input  wire logic tx_fail,
    // Sink side outputs
    output logic      tx_hard_reset,
    output logic      prepare_req,
    output logic      prep_done_ind,
    output logic      prep_late,
    output logic      pst_running,
    output logic      pst_fail,
    // Source side outputs
    output logic      hr_notify,
    output logic      reset_order,
    output logic      vbus_enable,
    output logic      discharge_fault,
    output logic      turnon_fault,
    output logic      hr_complete,
    // Message requests and completion
    output logic      tx_accept,
    output logic      tx_ps_rdy,
    output logic      goodcrc_tx,
    output logic      exchange_done
);
    // Refuse counts the timer cannot hold or that would vanish
    if (SINK_PREP_CYCLES == 0 || SRC_WAIT_CYCLES == 0 || DISCHARGE_CYCLES == 0 ||
        RECOVERY_CYCLES == 0 || TURN_ON_CYCLES == 0 || TRANSITION_CYCLES == 0 ||
        PST_CYCLES == 0) begin : g_bad_count
        $error("pdseq_top: every cycle count must be at least one");
    end

    pdseq_top_s  r_reg;
    pdseq_top_s  r_next;
    pdseq_tmr_if tmr ();

    pdseq_timer u_timer (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .t       (tmr.tmr)
    );

    // Outputs straight from the state register
    assign tx_hard_reset   = r_reg.tx_hard_reset;
    assign prepare_req     = r_reg.prepare_req;
    assign prep_done_ind   = r_reg.prep_done_ind;
    assign prep_late       = r_reg.prep_late;
    assign pst_running     = r_reg.pst_running;
    assign pst_fail        = r_reg.pst_fail;
    assign hr_notify       = r_reg.hr_notify;
    assign reset_order     = r_reg.reset_order;
    assign vbus_enable     = r_reg.vbus_enable;
    assign discharge_fault = r_reg.discharge_fault;
    assign turnon_fault    = r_reg.turnon_fault;
    assign hr_complete     = r_reg.hr_complete;
    assign tx_accept       = r_reg.tx_accept;
    assign tx_ps_rdy       = r_reg.tx_ps_rdy;
    assign goodcrc_tx      = r_reg.goodcrc_tx;
    assign exchange_done   = r_reg.exchange_done;

    // Next state; pulses default low, the timer is shared by all phases
    always_comb begin
        r_next               = r_reg;
        r_next.tx_hard_reset = 1'h0;
        r_next.prepare_req   = 1'h0;
        r_next.prep_done_ind = 1'h0;
        r_next.prep_late     = 1'h0;
        r_next.pst_fail      = 1'h0;
        r_next.hr_notify     = 1'h0;
        r_next.reset_order   = 1'h0;
        r_next.discharge_fault = 1'h0;
        r_next.turnon_fault  = 1'h0;
        r_next.hr_complete   = 1'h0;
        r_next.tx_accept     = 1'h0;
        r_next.tx_ps_rdy     = 1'h0;
        r_next.goodcrc_tx    = 1'h0;
        r_next.exchange_done = 1'h0;
        tmr.start            = 1'h0;
        tmr.stop             = 1'h0;
        tmr.load_val         = '0;
        // Comparator pins: three flops, level moves only when stages two and three agree
        r_next.sync0 = {vbus_at_default_pin, vbus_at_zero_pin};
        r_next.sync1 = r_reg.sync0;
        r_next.sync2 = r_reg.sync1;
        for (int i = 0; i < 2; i++) begin
            if (r_reg.sync1[i] == r_reg.sync2[i]) begin
                r_next.lvl[i] = r_reg.sync2[i];
            end
        end
        unique case (r_reg.state)
            ST_IDLE: begin
                if (role_source) begin
                    if (hard_reset_rx) begin
                        r_next.hr_notify = 1'h1;
                        tmr.start        = 1'h1;
                        tmr.load_val     = TMR_W'(SRC_WAIT_CYCLES);
                        r_next.state     = ST_SRC_HR_WAIT;
                    end else if (same_req_rx && (no_change_dpm || no_change_supply)) begin
                        r_next.tx_accept = 1'h1;
                        r_next.state     = ST_SRC_ACC_ACK;
                    end
                end else if (sink_hr_req) begin
                    r_next.tx_hard_reset = 1'h1;
                    r_next.state         = ST_SNK_SIGNAL;
                end else if (accept_rx) begin
                    r_next.goodcrc_tx  = 1'h1;
                    r_next.pst_running = 1'h1;
                    tmr.start          = 1'h1;
                    tmr.load_val       = TMR_W'(PST_CYCLES);
                    r_next.state       = ST_SNK_WAIT;
                end
            end
            ST_SNK_SIGNAL: begin
                // Signaling has gone out; now the power path prepares
                r_next.prepare_req = 1'h1;
                tmr.start          = 1'h1;
                tmr.load_val       = TMR_W'(SINK_PREP_CYCLES);
                r_next.state       = ST_SNK_PREP;
            end
            ST_SNK_PREP: begin
                // Completion is forced at the limit so the manager is never left waiting
                if (prep_ready || tmr.done) begin
                    r_next.prep_done_ind = 1'h1;
                    r_next.prep_late     = !prep_ready;
                    tmr.stop             = 1'h1;
                    r_next.state         = ST_IDLE;
                end
            end
            ST_SNK_WAIT: begin
                if (ps_rdy_rx) begin
                    r_next.goodcrc_tx    = 1'h1;
                    r_next.exchange_done = 1'h1;
                    r_next.pst_running   = 1'h0;
                    tmr.stop             = 1'h1;
                    r_next.state         = ST_IDLE;
                end else if (tmr.done) begin
                    r_next.pst_fail      = 1'h1;
                    r_next.pst_running   = 1'h0;
                    r_next.tx_hard_reset = 1'h1;
                    r_next.state         = ST_SNK_SIGNAL;
                end
            end
            ST_SRC_HR_WAIT: begin
                if (tmr.done) begin
                    r_next.reset_order = 1'h1;
                    r_next.vbus_enable = 1'h0;
                    tmr.start          = 1'h1;
                    tmr.load_val       = TMR_W'(DISCHARGE_CYCLES);
                    r_next.state       = ST_SRC_DISCH;
                end
            end
            ST_SRC_DISCH: begin
                // Recovery runs even after a late discharge; the fault flags it
                if (r_reg.lvl[LVL_ZERO] || tmr.done) begin
                    r_next.discharge_fault = !r_reg.lvl[LVL_ZERO];
                    tmr.start              = 1'h1;
                    tmr.load_val           = TMR_W'(RECOVERY_CYCLES);
                    r_next.state           = ST_SRC_RECOVER;
                end
            end
            ST_SRC_RECOVER: begin
                if (tmr.done) begin
                    r_next.vbus_enable = 1'h1;
                    tmr.start          = 1'h1;
                    tmr.load_val       = TMR_W'(TURN_ON_CYCLES);
                    r_next.state       = ST_SRC_TURN_ON;
                end
            end
            ST_SRC_TURN_ON: begin
                if (r_reg.lvl[LVL_DEF] || tmr.done) begin
                    r_next.turnon_fault = !r_reg.lvl[LVL_DEF];
                    r_next.hr_complete  = r_reg.lvl[LVL_DEF];
                    tmr.stop            = 1'h1;
                    r_next.state        = ST_IDLE;
                end
            end
            ST_SRC_ACC_ACK: begin
                // The delay counts only from the acknowledged Accept
                if (goodcrc_rx) begin
                    tmr.start    = 1'h1;
                    tmr.load_val = TMR_W'(TRANSITION_CYCLES);
                    r_next.state = ST_SRC_TRANS;
                end else if (tx_fail) begin
                    r_next.state = ST_IDLE;
                end
            end
            ST_SRC_TRANS: begin
                if (tmr.done) begin
                    r_next.tx_ps_rdy = 1'h1;
                    r_next.state     = ST_SRC_RDY_ACK;
                end
            end
            ST_SRC_RDY_ACK: begin
                if (goodcrc_rx || tx_fail) begin
                    r_next.exchange_done = goodcrc_rx;
                    r_next.state         = ST_IDLE;
                end
            end
            default: begin
                r_next.state = ST_IDLE;
            end
        endcase
        // Hard Reset from the Sink pre-empts a no-change exchange in progress
        if (role_source && hard_reset_rx &&
            (r_reg.state inside {ST_SRC_ACC_ACK, ST_SRC_TRANS, ST_SRC_RDY_ACK})) begin
            r_next.hr_notify     = 1'h1;
            r_next.tx_ps_rdy     = 1'h0;
            r_next.exchange_done = 1'h0;
            tmr.start            = 1'h1;
            tmr.load_val         = TMR_W'(SRC_WAIT_CYCLES);
            r_next.state         = ST_SRC_HR_WAIT;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            r_reg <= TOP_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_sink_signal;
        tx_hard_reset && r_reg.state == ST_SNK_SIGNAL;
    endsequence

    sequence s_src_hr_start;
        role_source && hard_reset_rx && r_reg.state == ST_IDLE;
    endsequence

    a_prep_after_signal:
    assert property (s_sink_signal |-> ##1 prepare_req && r_reg.state == ST_SNK_PREP)
        else $error("prepare request did not follow hard reset signaling");

    a_prep_done_source:
    assert property ($rose(prep_done_ind) |-> $past(r_reg.state) == ST_SNK_PREP)
        else $error("preparation completion outside the prepare phase");

    a_hr_notify_wait:
    assert property (s_src_hr_start |=> hr_notify && r_reg.state == ST_SRC_HR_WAIT)
        else $error("source did not notify on hard reset");

    a_reset_order_timed:
    assert property (reset_order |-> !vbus_enable && r_reg.state == ST_SRC_DISCH &&
                     $past(r_reg.state) == ST_SRC_HR_WAIT)
        else $error("supply reset ordered outside the wait phase");

    a_power_restore:
    assert property ($rose(vbus_enable) |-> r_reg.state == ST_SRC_TURN_ON &&
                     $past(r_reg.state) == ST_SRC_RECOVER)
        else $error("default power restored outside recovery");

    a_accept_reply:
    assert property (role_source && same_req_rx && no_change_supply && r_reg.state == ST_IDLE &&
                     !hard_reset_rx |=> tx_accept ##1 !tx_accept)
        else $error("no single accept for same request");

    a_sink_accept:
    assert property (!role_source && accept_rx && !sink_hr_req && r_reg.state == ST_IDLE
                     |=> goodcrc_tx && pst_running)
        else $error("sink did not ack accept and start timer");

    a_rdy_needs_ack:
    assert property ($rose(tx_ps_rdy) |-> $past(r_reg.state) == ST_SRC_TRANS)
        else $error("ps ready sent without transition delay");

    a_rdy_completes:
    assert property (r_reg.state == ST_SNK_WAIT && ps_rdy_rx |=> goodcrc_tx && exchange_done &&
                     !pst_running ##1 !exchange_done)
        else $error("sink did not finish on ps ready");

    a_pst_escalate:
    assert property (pst_fail |-> tx_hard_reset ##1 prepare_req)
        else $error("timer expiry did not escalate to hard reset");
endmodule
`default_nettype wire

/* File: tb/pd_hard_reset_and_null_contract_seq_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the Hard Reset and no-change sequencer
module pd_hard_reset_and_null_contract_seq_bench;
    // Short timer figures keep the run brief; a transition of 2 reaches the timer's own check
    localparam int SPREP = 6, SWAIT = 4, DISCH = 8, RECOV = 5, TURN = 12, TRANS = 2, PST = 10;
    logic ref_clk = 0, resetn = 0, role_source = 0, sink_hr_req = 0, no_change_dpm = 0;
    logic no_change_supply = 0, prep_ready = 0, hard_reset_rx = 0, same_req_rx = 0;
    logic accept_rx = 0, ps_rdy_rx = 0, tx_fail = 0, bus_stuck = 0;
    logic [2:0] ack_delay = 3'h1;
    logic goodcrc_rx, vbus_at_zero_pin, vbus_at_default_pin, tx_hard_reset, prepare_req;
    logic prep_done_ind, prep_late, pst_running, pst_fail, hr_notify, reset_order, vbus_enable;
    logic discharge_fault, turnon_fault, hr_complete, tx_accept, tx_ps_rdy, goodcrc_tx, exchange_done;
    int failures = 0, cmp_count = 0, cyc = 0, disch_n = 0, rdy_n = 0, k, t, u;
    integer seed = 68;

    pdseq_top #(.SINK_PREP_CYCLES(SPREP), .SRC_WAIT_CYCLES(SWAIT), .DISCHARGE_CYCLES(DISCH),
        .RECOVERY_CYCLES(RECOV), .TURN_ON_CYCLES(TURN), .TRANSITION_CYCLES(TRANS), .PST_CYCLES(PST)) DUT (
        .ref_clk, .resetn, .role_source, .sink_hr_req, .no_change_dpm, .no_change_supply, .prep_ready,
        .vbus_at_zero_pin, .vbus_at_default_pin, .hard_reset_rx, .same_req_rx, .accept_rx, .ps_rdy_rx,
        .goodcrc_rx, .tx_fail, .tx_hard_reset, .prepare_req, .prep_done_ind, .prep_late, .pst_running,
        .pst_fail, .hr_notify, .reset_order, .vbus_enable, .discharge_fault, .turnon_fault, .hr_complete,
        .tx_accept, .tx_ps_rdy, .goodcrc_tx, .exchange_done);

    pdseq_peer PEER (.ref_clk, .resetn, .tx_accept, .tx_ps_rdy, .vbus_enable, .ack_delay, .bus_stuck,
        .goodcrc_rx, .vbus_at_zero_pin, .vbus_at_default_pin);

    // Clock at 40 MHz
    always #12.5 ref_clk = ~ref_clk;

    // Cycle count and tallies of discharge faults and PS_RDY requests, all single-cycle pulses
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (discharge_fault === 1'b1) disch_n <= disch_n + 1;
        if (tx_ps_rdy === 1'b1) rdy_n <= rdy_n + 1;
    end

    // Inputs always move 2 ns after the edge so no race with the design's flops
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_cyc(input string nm, input int e, input int g);
        cmp_count++;
        if (g != e) begin
            failures++;
            $display("ERROR %s expected cycle %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Bounded wait for a high level; a hang counts as a mismatch
    task automatic wait_hi(ref logic s, input string nm, output int at);
        for (int i = 0; i < 200; i++) begin
            if (s === 1'b1) begin
                at = cyc;
                return;
            end
            step(1);
        end
        failures++;
        $display("ERROR %s expected 1 seen timeout", nm);
        complete_run();
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask

    // Main sequence
    initial begin
        step(5);
        chk("reset_outputs", 16'h0040, {tx_hard_reset, prepare_req, prep_done_ind, prep_late, pst_running,
            pst_fail, hr_notify, reset_order, 1'b0, vbus_enable, discharge_fault, turnon_fault, hr_complete,
            tx_accept, tx_ps_rdy, exchange_done | goodcrc_tx});
        resetn = 1'b1;
        step(1);
        // Sink reset with prompt preparation, then with preparation that never ends
        k = cyc;
        pulse(sink_hr_req);
        wait_hi(tx_hard_reset, "tx_hard_reset", t);
        chk_cyc("tx_hard_reset", k + 1, t);
        step(1);
        chk("prepare_req", 1, prepare_req);
        step(2);
        pulse(prep_ready);
        chk("prep_done_late", 2'b10, {prep_done_ind, prep_late});
        step(1);
        pulse(sink_hr_req);
        step(1);
        u = cyc;
        wait_hi(prep_done_ind, "prep_done_ind", t);
        chk("prep_late", 1, prep_late);
        chk("prep_limit", 1, (t - u >= SPREP) && (t - u <= SPREP + 1));
        $display("sink hard reset tests done");
        // Source reset with a healthy supply, one that never discharges, one that never turns on
        role_source = 1'b1;
        for (int s = 0; s < 3; s++) begin
            bus_stuck = (s == 1);
            step(1);
            k = cyc;
            pulse(hard_reset_rx);
            chk("hr_notify", 1, hr_notify);
            wait_hi(reset_order, "reset_order", t);
            chk_cyc("reset_order", k + 1 + SWAIT, t);
            chk("vbus_off", 0, vbus_enable);
            if (s == 1) begin
                wait_hi(discharge_fault, "discharge_fault", u);
                chk("disch_limit", 1, (u - t >= DISCH) && (u - t <= DISCH + 1));
            end
            wait_hi(vbus_enable, "vbus_enable", u);
            bus_stuck = (s == 2);
            chk("recovery", 1, u - t >= RECOV);
            if (s == 2) begin
                wait_hi(turnon_fault, "turnon_fault", t);
                chk_cyc("turnon_fault", u + TURN, t);
            end else begin
                wait_hi(hr_complete, "hr_complete", t);
                chk("turn_on", 1, t - u <= TURN + 1);
            end
            chk("disch_count", 16'(s != 0), 16'(disch_n));
            step(1);
        end
        bus_stuck = 1'b0;
        $display("source hard reset tests done");
        // Source no-change: supply decides, policy manager decides, nobody decides
        for (int i = 1; i <= 3; i++) begin
            {no_change_dpm, no_change_supply} = 2'(i % 3);
            ack_delay = 3'(1 + ($random(seed) & 3));
            pulse(same_req_rx);
            chk("tx_accept", 16'(i < 3), tx_accept);
            if (i < 3) begin
                wait_hi(goodcrc_rx, "goodcrc_rx", t);
                wait_hi(tx_ps_rdy, "tx_ps_rdy", u);
                chk_cyc("tx_ps_rdy", t + 1 + TRANS, u);
                step(1);
                wait_hi(goodcrc_rx, "goodcrc_rx", t);
                step(1);
                chk("exchange_done", 1, exchange_done);
            end
            step(2);
        end
        // A failed Accept send drops the exchange, so no PS_RDY may follow
        no_change_supply = 1'b1;
        pulse(same_req_rx);
        pulse(tx_fail);
        step(12);
        chk("rdy_count", 16'h0002, 16'(rdy_n));
        $display("source no-change tests done");
        // Sink no-change answered by PS_RDY, then left without it
        role_source = 1'b0;
        step(1);
        pulse(accept_rx);
        chk("accept_seen", 2'b11, {goodcrc_tx, pst_running});
        step(1 + ($random(seed) & 3));
        pulse(ps_rdy_rx);
        chk("ps_rdy_seen", 3'b110, {goodcrc_tx, exchange_done, pst_running});
        step(1);
        k = cyc;
        pulse(accept_rx);
        wait_hi(pst_fail, "pst_fail", t);
        chk_cyc("pst_fail", k + 1 + PST, t);
        chk("escalate", 1, tx_hard_reset);
        step(1);
        chk("prepare_req", 1, prepare_req);
        step(1);
        pulse(prep_ready);
        chk("prep_done", 1, prep_done_ind);
        $display("sink no-change tests done");
        complete_run();
    end
endmodule
`default_nettype wire

/* File: tb/pdseq_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// Far port and its supply: answers messages with GoodCRC and models the bus levels
module pdseq_peer (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // Messages and supply enable from the block
    input  wire logic       tx_accept,
    input  wire logic       tx_ps_rdy,
    input  wire logic       vbus_enable,
    // Model controls from the bench
    input  wire logic [2:0] ack_delay,
    input  wire logic       bus_stuck,
    // Answers to the block
    output logic            goodcrc_rx,
    output logic            vbus_at_zero_pin,
    output logic            vbus_at_default_pin
);
    logic [2:0] ack_cnt;
    logic [2:0] en_dly;

    // GoodCRC ack_delay+1 cycles after each message; the bench keeps ack_delay above 0
    always @(posedge ref_clk) begin
        goodcrc_rx <= 1'b0;
        if (!resetn) begin
            ack_cnt <= 3'h0;
        end else if (tx_accept || tx_ps_rdy) begin
            ack_cnt <= ack_delay;
        end else if (ack_cnt != 3'h0) begin
            ack_cnt    <= ack_cnt - 3'h1;
            goodcrc_rx <= (ack_cnt == 3'h1);
        end
    end

    // Bus lags the enable by three cycles; a stuck supply never moves, to provoke faults
    always @(posedge ref_clk) begin
        if (!resetn) begin
            en_dly <= 3'h7;
        end else if (!bus_stuck) begin
            en_dly <= {en_dly[1:0], vbus_enable};
        end
    end
    assign vbus_at_zero_pin    = !en_dly[2];
    assign vbus_at_default_pin = en_dly[2];
endmodule
`default_nettype wire
